// ===== common/dma_pkg.sv
// shared constants and types for the peripheral ram dma channel
package dma_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] RD_PTR_OFS  = 8'h00;
  localparam logic [7:0] RD_MAX_OFS  = 8'h04;
  localparam logic [7:0] RD_AMT_OFS  = 8'h08;
  localparam logic [7:0] RD_LIST_OFS = 8'h0c;
  localparam logic [7:0] WR_PTR_OFS  = 8'h10;
  localparam logic [7:0] WR_MAX_OFS  = 8'h14;
  localparam logic [7:0] WR_AMT_OFS  = 8'h18;
  localparam logic [7:0] WR_LIST_OFS = 8'h1c;
  localparam logic [7:0] TASK_OFS    = 8'h20;
  localparam logic [7:0] CFG_OFS     = 8'h24;
  localparam logic [7:0] STAT_OFS    = 8'h28;
  localparam logic [7:0] DROP_OFS    = 8'h2c;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int TASK_RD_START = 0;
  localparam int TASK_WR_START = 1;
  localparam int TASK_STOP     = 2;
  localparam int CFG_DROP      = 0;
  localparam int ST_RD_BUSY    = 0;
  localparam int ST_WR_BUSY    = 1;
  localparam int ST_RD_END     = 2;
  localparam int ST_WR_END     = 3;
  localparam int ST_RD_FAULT   = 4;
  localparam int ST_WR_FAULT   = 5;
  localparam logic [31:0] PTR_RST  = 32'h0000_0000;
  localparam logic [31:0] RAM_BASE = 32'h2000_0000;
  localparam logic [31:0] RAM_SIZE = 32'h0001_0000;
  // ---------------------------------------------------------------
  // bus encodings and states
  // ---------------------------------------------------------------
  localparam logic [1:0] TR_IDLE   = 2'h0;
  localparam logic [1:0] TR_NONSEQ = 2'h2;
  localparam logic [2:0] SZ_BYTE   = 3'h0;
  localparam logic [2:0] BU_SINGLE = 3'h0;
  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA} mst_state_type;

  // address lies inside the data ram window
  function automatic logic in_ram(input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
    in_ram = (a >= b) && ((a - b) < s);
  endfunction
endpackage

// ===== hdl/dma_chan.sv
// one dma channel: working address, remaining and moved byte counts
`timescale 1ns/1ps
module dma_chan #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic             fault,
  input  wire logic             beat,
  input  wire logic             list_en,
  input  wire logic             ptr_wr,
  input  wire logic [31:0]      ptr,
  input  wire logic [CNT_W-1:0] max_byte_count,
  output logic [31:0]           addr,
  output logic [CNT_W-1:0]      transferred_byte_count,
  output logic                  busy,
  output logic                  done
);
  logic [31:0]      next_q;
  logic [31:0]      base;
  logic [CNT_W-1:0] left_q;

  // item start: fixed pointer, or the next item in list mode
  assign base = list_en ? next_q : ptr;

  // ---------------------------------------------------------------
  // list cursor
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      next_q <= dma_pkg::PTR_RST;
    end else if (start) begin
      next_q <= base + 32'(max_byte_count);
    end else if (ptr_wr) begin
      next_q <= ptr;
    end
  end

  // ---------------------------------------------------------------
  // transfer progress
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr   <= dma_pkg::PTR_RST;
      left_q <= '0;
      transferred_byte_count <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        addr   <= base;
        left_q <= max_byte_count;
        transferred_byte_count <= '0;
        busy   <= (max_byte_count != '0);
        done   <= (max_byte_count == '0);
      end else if (busy && beat) begin
        addr   <= addr + 32'h1;
        left_q <= left_q - 1'b1;
        transferred_byte_count <= transferred_byte_count + 1'b1;
        busy   <= (left_q != CNT_W'(1));
        done   <= (left_q == CNT_W'(1));
      end else if (busy && (stop || fault)) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end

  chk_list_step: assert property (@(posedge clk) disable iff (!rst_n)
    start && list_en |=> next_q == addr + 32'($past(max_byte_count)))
    else $error("list item not advanced by max byte count");
  chk_amt_bound: assert property (@(posedge clk) disable iff (!rst_n)
    busy && !start |=> CNT_W'(transferred_byte_count + left_q) == $past(CNT_W'(transferred_byte_count + left_q)))
    else $error("moved plus left count drifted");
endmodule // dma_chan

// ===== hdl/ahb_byte_port.sv
// single byte ahb-lite master port shared by the channels
`timescale 1ns/1ps
module ahb_byte_port (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        req_wr,
  input  wire logic [31:0] req_addr,
  input  wire logic [7:0]  req_data,
  output logic             idle,
  output logic             done,
  output logic             err,
  output logic [7:0]       rdata,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [31:0]      hwdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hready,
  input  wire logic        hresp
);
  dma_pkg::mst_state_type state_q;
  logic [7:0]             wbyte_q;

  assign idle  = (state_q == dma_pkg::M_IDLE);
  assign done  = (state_q == dma_pkg::M_DATA) && hready;
  assign err   = done && hresp;
  assign rdata = hrdata[8*haddr[1:0] +: 8];

  // ---------------------------------------------------------------
  // address and data phase sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dma_pkg::M_IDLE;
      haddr   <= '0;
      htrans  <= dma_pkg::TR_IDLE;
      hwrite  <= 1'b0;
      hwdata  <= '0;
      wbyte_q <= '0;
    end else begin
      unique case (state_q)
        dma_pkg::M_IDLE: if (req) begin
          haddr   <= req_addr;
          htrans  <= dma_pkg::TR_NONSEQ;
          hwrite  <= req_wr;
          wbyte_q <= req_data;
          state_q <= dma_pkg::M_ADDR;
        end
        dma_pkg::M_ADDR: if (hready) begin
          htrans  <= dma_pkg::TR_IDLE;
          hwdata  <= {4{wbyte_q}};
          state_q <= dma_pkg::M_DATA;
        end
        dma_pkg::M_DATA: if (hready) begin
          state_q <= dma_pkg::M_IDLE;
        end
      endcase
    end
  end

  chk_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    htrans == dma_pkg::TR_NONSEQ && !hready |=> htrans == dma_pkg::TR_NONSEQ && $stable(haddr))
    else $error("address phase changed while stalled");
  chk_beat_time: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == dma_pkg::M_ADDR && hready ##1 hready |-> done)
    else $error("granted beat did not finish");
endmodule // ahb_byte_port

// ===== hdl/peripheral_ram_dma_channel.sv
// peripheral ram dma: read and write channels over one ahb master
// Function
// - each channel is an ahb bus master reaching data ram directly; here both channels share one ahb master port.
// - no transfer ever addresses flash; only the data ram window.
// - independent read and write channels, each with own pointer and counts.
// - read fetches max byte count from pointer; write stores at most that.
// - after a transfer the moved byte count is readable.
// - pointer reset value need not address valid memory.
// - bad pointers may fault or corrupt ram; no pointer checking needed.
// - when the bus is busy the peripheral stalls or drops data.
// - list mode only in channels owning a list select register.
// - list mode keeps no next link; items lie back to back.
// - each list item is max byte count bytes; that count ends it.
// - the highest priority master wins; others stall until it completes.
// - a paused higher master lets a waiting lower master in meanwhile.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module peripheral_ram_dma_channel #(
  parameter int          CNT_W       = 16,
  parameter bit          RD_HAS_LIST = 1'b1,
  parameter bit          WR_HAS_LIST = 1'b0,
  parameter logic [31:0] RAM_LO      = dma_pkg::RAM_BASE,
  parameter logic [31:0] RAM_SZ      = dma_pkg::RAM_SIZE
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  output logic [7:0]       RD_DATA,
  output logic             RD_VALID,
  input  wire logic        RD_READY,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic        WR_VALID,
  output logic             WR_READY,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [2:0]       HSIZE,
  output logic [2:0]       HBURST,
  output logic [31:0]      HWDATA,
  input  wire logic [31:0] HRDATA,
  input  wire logic        HREADY,
  input  wire logic        HRESP
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0]      rd_ptr_q, wr_ptr_q, rd_addr, wr_addr;
  logic [CNT_W-1:0] rd_max_q, wr_max_q, rd_amt, wr_amt;
  logic             rd_list_q, wr_list_q, drop_q, stop_q;
  logic             rd_busy, wr_busy, rd_done, wr_done;
  logic             rd_end_q, wr_end_q, rd_flt_q, wr_flt_q;
  logic [15:0]      drop_cnt_q;
  logic [7:0]       wr_byte_q;
  logic             wr_full_q, own_wr_q;
  logic             m_idle, m_done, m_err, m_req;
  logic [7:0]       m_rdata;
  logic             want_wr, want_rd, pick_wr, pick_ok;
  logic             rd_start, wr_start, rd_beat, wr_beat;
  logic             rd_flt, wr_flt, accept, drop;
  logic [31:0]      pick_addr;

  assign HSIZE  = dma_pkg::SZ_BYTE;
  assign HBURST = dma_pkg::BU_SINGLE;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ptr_q  <= dma_pkg::PTR_RST;
      wr_ptr_q  <= dma_pkg::PTR_RST;
      rd_max_q  <= '0;
      wr_max_q  <= '0;
      rd_list_q <= 1'b0;
      wr_list_q <= 1'b0;
      drop_q    <= 1'b0;
    end else if (WR) begin
      unique case (ADDR)
        dma_pkg::RD_PTR_OFS:  rd_ptr_q  <= WDATA;
        dma_pkg::RD_MAX_OFS:  rd_max_q  <= WDATA[CNT_W-1:0];
        dma_pkg::RD_LIST_OFS: rd_list_q <= WDATA[0] & RD_HAS_LIST;
        dma_pkg::WR_PTR_OFS:  wr_ptr_q  <= WDATA;
        dma_pkg::WR_MAX_OFS:  wr_max_q  <= WDATA[CNT_W-1:0];
        dma_pkg::WR_LIST_OFS: wr_list_q <= WDATA[0] & WR_HAS_LIST;
        dma_pkg::CFG_OFS:     drop_q    <= WDATA[dma_pkg::CFG_DROP];
        default: ;
      endcase
    end
  end

  // start strobes from the task register
  assign rd_start = WR && ADDR == dma_pkg::TASK_OFS && WDATA[dma_pkg::TASK_RD_START];
  assign wr_start = WR && ADDR == dma_pkg::TASK_OFS && WDATA[dma_pkg::TASK_WR_START];

  // stop waits until no beat is on the bus
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_q <= 1'b0;
    end else if (WR && ADDR == dma_pkg::TASK_OFS && WDATA[dma_pkg::TASK_STOP]) begin
      stop_q <= 1'b1;
    end else if (m_idle) begin
      stop_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // the two channels
  // ---------------------------------------------------------------
  dma_chan #(.CNT_W(CNT_W)) u_rd (
    .clk    (CLK),
    .rst_n  (RST_N),
    .start  (rd_start),
    .stop   (stop_q && m_idle),
    .fault  (rd_flt),
    .beat   (rd_beat),
    .list_en(rd_list_q),
    .ptr_wr (WR && ADDR == dma_pkg::RD_PTR_OFS),
    .ptr    ((WR && ADDR == dma_pkg::RD_PTR_OFS) ? WDATA : rd_ptr_q), // the list cursor loads the pointer being written
    .max_byte_count (rd_max_q),
    .addr   (rd_addr),
    .transferred_byte_count (rd_amt),
    .busy   (rd_busy),
    .done   (rd_done)
  );

  dma_chan #(.CNT_W(CNT_W)) u_wr (
    .clk    (CLK),
    .rst_n  (RST_N),
    .start  (wr_start),
    .stop   (stop_q && m_idle),
    .fault  (wr_flt),
    .beat   (wr_beat),
    .list_en(wr_list_q),
    .ptr_wr (WR && ADDR == dma_pkg::WR_PTR_OFS),
    .ptr    ((WR && ADDR == dma_pkg::WR_PTR_OFS) ? WDATA : wr_ptr_q), // the list cursor loads the pointer being written
    .max_byte_count (wr_max_q),
    .addr   (wr_addr),
    .transferred_byte_count (wr_amt),
    .busy   (wr_busy),
    .done   (wr_done)
  );

  // ---------------------------------------------------------------
  // bus request selection, write channel first
  // ---------------------------------------------------------------
  assign want_wr   = wr_busy && wr_full_q && !stop_q;
  assign want_rd   = rd_busy && !RD_VALID && !stop_q;
  assign pick_wr   = want_wr;
  assign pick_addr = pick_wr ? wr_addr : rd_addr;
  assign pick_ok   = dma_pkg::in_ram(pick_addr, RAM_LO, RAM_SZ);
  assign m_req     = m_idle && (want_wr || want_rd) && pick_ok;
  assign rd_flt    = (m_idle && !pick_wr && want_rd && !pick_ok) || (m_err && !own_wr_q);
  assign wr_flt    = (m_idle && pick_wr && !pick_ok) || (m_err && own_wr_q);
  assign rd_beat   = m_done && !m_err && !own_wr_q;
  assign wr_beat   = m_done && !m_err && own_wr_q;

  // owner of the beat in flight
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      own_wr_q <= 1'b0;
    end else if (m_req) begin
      own_wr_q <= pick_wr;
    end
  end

  ahb_byte_port u_port (
    .clk     (CLK),
    .rst_n   (RST_N),
    .req     (m_req),
    .req_wr  (pick_wr),
    .req_addr(pick_addr),
    .req_data(wr_byte_q),
    .idle    (m_idle),
    .done    (m_done),
    .err     (m_err),
    .rdata   (m_rdata),
    .haddr   (HADDR),
    .htrans  (HTRANS),
    .hwrite  (HWRITE),
    .hwdata  (HWDATA),
    .hrdata  (HRDATA),
    .hready  (HREADY),
    .hresp   (HRESP)
  );

  // ---------------------------------------------------------------
  // peripheral side byte streams
  // ---------------------------------------------------------------
  // fetched byte waits for the peripheral
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA  <= '0;
      RD_VALID <= 1'b0;
    end else if (rd_beat) begin
      RD_DATA  <= m_rdata;
      RD_VALID <= 1'b1;
    end else if (RD_READY) begin
      RD_VALID <= 1'b0;
    end
  end

  // stall mode refuses bytes; drop mode takes and loses them
  assign WR_READY = wr_busy && (drop_q || !wr_full_q);
  assign accept   = WR_VALID && wr_busy && !wr_full_q;
  assign drop     = WR_VALID && wr_busy && wr_full_q && drop_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_byte_q <= '0;
      wr_full_q <= 1'b0;
    end else if (accept) begin
      wr_byte_q <= WR_DATA;
      wr_full_q <= 1'b1;
    end else if (wr_beat || wr_flt || !wr_busy) begin
      wr_full_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      drop_cnt_q <= '0;
    end else if (drop) begin
      drop_cnt_q <= drop_cnt_q + 16'h1;
    end
  end

  // ---------------------------------------------------------------
  // sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_end_q <= 1'b0;
      wr_end_q <= 1'b0;
      rd_flt_q <= 1'b0;
      wr_flt_q <= 1'b0;
    end else begin
      if (WR && ADDR == dma_pkg::STAT_OFS) begin
        rd_end_q <= rd_end_q & ~WDATA[dma_pkg::ST_RD_END];
        wr_end_q <= wr_end_q & ~WDATA[dma_pkg::ST_WR_END];
        rd_flt_q <= rd_flt_q & ~WDATA[dma_pkg::ST_RD_FAULT];
        wr_flt_q <= wr_flt_q & ~WDATA[dma_pkg::ST_WR_FAULT];
      end
      if (rd_done) rd_end_q <= 1'b1;
      if (wr_done) wr_end_q <= 1'b1;
      if (rd_flt && rd_busy) rd_flt_q <= 1'b1;
      if (wr_flt && wr_busy) wr_flt_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // register reads, data in the next cycle
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else if (RD) begin
      unique case (ADDR)
        dma_pkg::RD_PTR_OFS:  RDATA <= rd_ptr_q;
        dma_pkg::RD_MAX_OFS:  RDATA <= 32'(rd_max_q);
        dma_pkg::RD_AMT_OFS:  RDATA <= 32'(rd_amt);
        dma_pkg::RD_LIST_OFS: RDATA <= {31'h0, rd_list_q};
        dma_pkg::WR_PTR_OFS:  RDATA <= wr_ptr_q;
        dma_pkg::WR_MAX_OFS:  RDATA <= 32'(wr_max_q);
        dma_pkg::WR_AMT_OFS:  RDATA <= 32'(wr_amt);
        dma_pkg::WR_LIST_OFS: RDATA <= {31'h0, wr_list_q};
        dma_pkg::CFG_OFS:     RDATA <= {31'h0, drop_q};
        dma_pkg::STAT_OFS:    RDATA <= {26'h0, wr_flt_q, rd_flt_q, wr_end_q, rd_end_q, wr_busy, rd_busy};
        dma_pkg::DROP_OFS:    RDATA <= {16'h0, drop_cnt_q};
        default:              RDATA <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_ram_only: assert property (
    HTRANS == dma_pkg::TR_NONSEQ |-> dma_pkg::in_ram(HADDR, RAM_LO, RAM_SZ))
    else $error("transfer outside data ram");
  chk_rd_count: assert property (
    rd_beat && rd_busy && !rd_start |=> rd_amt == $past(rd_amt) + 1'b1)
    else $error("read count did not step");
  chk_wr_apart: assert property (
    rd_beat && !wr_start |=> $stable(wr_amt))
    else $error("read beat touched write count");
  chk_rd_limit: assert property (
    rd_done && !$past(rd_flt) && !$past(stop_q) |-> rd_amt == rd_max_q)
    else $error("read moved other than max count");
  chk_wr_limit: assert property (
    wr_busy |-> wr_amt < wr_max_q)
    else $error("write count passed max count");
  chk_end_flag: assert property (
    rd_done |=> rd_end_q [*2] or (rd_end_q ##1 $past(WR)))
    else $error("end flag not raised");
  chk_stall_drop: assert property (
    drop |=> drop_cnt_q == $past(drop_cnt_q) + 16'h1 && $stable(wr_byte_q))
    else $error("dropped byte not counted");
  chk_stall_mode: assert property (
    !drop_q && wr_full_q |-> !WR_READY)
    else $error("stall mode accepted into full slot");
  chk_list_off: assert property (
    !WR_HAS_LIST |-> !wr_list_q)
    else $error("list mode on a channel without list");
  chk_prio_wr: assert property (
    m_req && want_wr |=> HWRITE && HADDR == $past(wr_addr))
    else $error("write channel lost priority");

  cov_rd_end:  cover property (rd_done && rd_amt == rd_max_q);
  cov_wr_end:  cover property (wr_done && wr_amt != '0);
  cov_drop:    cover property (drop);
  cov_list:    cover property (rd_start && rd_list_q ##[1:50] rd_start);
  cov_stalled: cover property (HTRANS == dma_pkg::TR_NONSEQ && !HREADY [*3]);
endmodule // peripheral_ram_dma_channel

// ===== tb/ahb_ram_model.sv
// behavioural data ram slave standing behind the ahb interconnect
`timescale 1ns/1ps
module ahb_ram_model (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        slow,
  output logic [31:0]      HRDATA,
  output logic             HREADY,
  output logic             HRESP
);
  // ---------------------------------------------------------------
  // ram array and one data phase
  // ---------------------------------------------------------------
  logic [7:0]  mem [0:255];
  logic        ph_q;
  logic        wr_q;
  logic        tog_q;
  logic [7:0]  a_q;
  logic [31:0] junk_q;
  // known fill: byte n holds n xor 5a
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  // a busier master holds the slave every other data cycle when slow
  assign HREADY = !(slow && ph_q && tog_q);
  assign HRESP  = 1'b0;
  // read data only in a read data phase, churning otherwise
  assign HRDATA = (ph_q && !wr_q) ? {4{mem[a_q]}} : junk_q;
  // address phase capture and write commit
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_q   <= 1'b0;
      wr_q   <= 1'b0;
      tog_q  <= 1'b0;
      a_q    <= 8'h00;
      junk_q <= 32'h3c96a55a;
    end else begin
      tog_q  <= !tog_q;
      junk_q <= {junk_q[30:0], !junk_q[31]};
      if (HREADY) begin
        if (ph_q && wr_q) mem[a_q] <= HWDATA[8*a_q[1:0] +: 8];
        ph_q <= (HTRANS == dma_pkg::TR_NONSEQ);
        wr_q <= HWRITE;
        a_q  <= HADDR[7:0];
      end
    end
  end
endmodule // ahb_ram_model

// ===== tb/peripheral_ram_dma_channel_tb_top.sv
// self-checking bench for the peripheral ram dma channel
`timescale 1ns/1ps
module peripheral_ram_dma_channel_tb_top;
  logic        CLK, RST_N, WR, RD, RD_VALID, RD_READY, WR_VALID, WR_READY, HWRITE, HREADY, HRESP, slow, got;
  logic [7:0]  ADDR, RD_DATA, WR_DATA;
  logic [31:0] WDATA, RDATA, HADDR, HWDATA, HRDATA, v, wcur, aa_q;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE, HBURST;
  logic        aph_q = 1'b0;
  logic        aw_q = 1'b0;
  logic        rs_q = 1'b0;
  logic [31:0] reg_q[$];
  logic [7:0]  byte_q[$];
  logic [39:0] beat_q[$];
  int          bad_count = 0;
  int          num_checks = 0;
  int          seed = 32'h0a1cf533;

  peripheral_ram_dma_channel dut_u (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_READY(RD_READY), .WR_DATA(WR_DATA),
    .WR_VALID(WR_VALID), .WR_READY(WR_READY), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HBURST(HBURST), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADY(HREADY), .HRESP(HRESP));
  ahb_ram_model ram_u (.CLK(CLK), .RST_N(RST_N), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HWDATA(HWDATA), .slow(slow), .HRDATA(HRDATA), .HREADY(HREADY), .HRESP(HRESP));

  // ---------------------------------------------------------------
  // compare, verdict and bus tasks
  // ---------------------------------------------------------------
  task automatic cmp(input string name, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rreg(input logic [7:0] a);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    v = RDATA;
  endtask
  // note the expected word, then read it
  task automatic xreg(input logic [7:0] a, input logic [31:0] e);
    reg_q.push_back(e);
    rreg(a);
  endtask
  // bounded wait for a status flag, then clear the sticky flags
  task automatic poll(input int b);
    int n;
    n = 0;
    v = 32'h0;
    while (v[b] !== 1'b1 && n < 300) begin
      rreg(dma_pkg::STAT_OFS);
      n++;
    end
    cmp("status flag", 40'h1, {39'h0, v[b]});
    wreg(dma_pkg::STAT_OFS, 32'h3c);
  endtask
  // offer one byte, note it as a ram beat if taken
  task automatic offer(input logic take);
    logic [7:0] d;
    int n;
    d = 8'($random(seed));
    n = 0;
    got = 1'b0;
    WR_VALID <= 1'b1;
    WR_DATA  <= d;
    while (!got && n < 40) begin
      @(posedge CLK);
      got = WR_READY;
      n++;
    end
    if (got) beat_q.push_back({wcur, d});
    if (got) wcur++;
    cmp("byte taken", {39'h0, take}, {39'h0, got});
  endtask

  // ---------------------------------------------------------------
  // clock, random consumer and watcher
  // ---------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK) RD_READY <= 1'($random(seed));
  // take the oldest note whenever a result appears
  always @(posedge CLK) begin
    rs_q <= RD;
    if (rs_q && reg_q.size() > 0) cmp("register", reg_q.pop_front(), RDATA);
    if (RD_VALID && RD_READY) cmp("fetched byte", byte_q.size() > 0 ? byte_q.pop_front() : 8'hxx, RD_DATA);
    if (HTRANS === dma_pkg::TR_NONSEQ) cmp("ram window", 40'h1,
      {39'h0, HADDR >= dma_pkg::RAM_BASE && HADDR < dma_pkg::RAM_BASE + dma_pkg::RAM_SIZE});
    if (HTRANS === dma_pkg::TR_NONSEQ) cmp("size burst", {34'h0, dma_pkg::SZ_BYTE, dma_pkg::BU_SINGLE},
      {34'h0, HSIZE, HBURST});
    if (aph_q && aw_q && HREADY) cmp("stored byte", beat_q.size() > 0 ? beat_q.pop_front() : 40'hx,
      {aa_q, HWDATA[7:0]});
    if (HREADY) aph_q <= (HTRANS === dma_pkg::TR_NONSEQ);
    if (HREADY) aw_q <= HWRITE;
    if (HREADY) aa_q <= HADDR;
  end
  // watchdog sized well above the longest run
  initial begin
    repeat (30000) @(posedge CLK);
    bad_count++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {RST_N, WR, RD, WR_VALID, slow} = 5'h0;
    {ADDR, WR_DATA, WDATA} = 48'h0;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    xreg(dma_pkg::RD_PTR_OFS, dma_pkg::PTR_RST);
    xreg(8'h30, 32'h0);
    // reset pointer lies outside ram: fault, no beat
    wreg(dma_pkg::RD_MAX_OFS, 32'h3);
    wreg(dma_pkg::TASK_OFS, 32'h1 << dma_pkg::TASK_RD_START);
    poll(dma_pkg::ST_RD_FAULT);
    xreg(dma_pkg::STAT_OFS, 32'h0);
    // single buffer over a stalling bus
    slow <= 1'b1;
    wreg(dma_pkg::RD_PTR_OFS, dma_pkg::RAM_BASE);
    wreg(dma_pkg::RD_MAX_OFS, 32'h5);
    for (int i = 0; i < 5; i++) byte_q.push_back(8'(i) ^ 8'h5a);
    wreg(dma_pkg::TASK_OFS, 32'h1 << dma_pkg::TASK_RD_START);
    poll(dma_pkg::ST_RD_END);
    xreg(dma_pkg::RD_AMT_OFS, 32'h5);
    slow <= 1'b0;
    // list mode: three items back to back
    wreg(dma_pkg::RD_LIST_OFS, 32'h1);
    wreg(dma_pkg::RD_PTR_OFS, dma_pkg::RAM_BASE + 32'h8);
    wreg(dma_pkg::RD_MAX_OFS, 32'h4);
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) byte_q.push_back(8'(8 + 4 * k + i) ^ 8'h5a);
      wreg(dma_pkg::TASK_OFS, 32'h1 << dma_pkg::TASK_RD_START);
      poll(dma_pkg::ST_RD_END);
      xreg(dma_pkg::RD_AMT_OFS, 32'h4);
    end
    // write channel: one byte over max refused; list bit has no effect there
    wreg(dma_pkg::WR_PTR_OFS, dma_pkg::RAM_BASE + 32'h40);
    for (int r = 0; r < 2; r++) begin
      wcur = dma_pkg::RAM_BASE + 32'h40;
      wreg(dma_pkg::WR_MAX_OFS, 32'(6 - 4 * r));
      wreg(dma_pkg::WR_LIST_OFS, 32'(r));
      wreg(dma_pkg::TASK_OFS, 32'h1 << dma_pkg::TASK_WR_START);
      for (int i = 0; i < 7 - 4 * r; i++) offer(i < 6 - 4 * r);
      WR_VALID <= 1'b0;
      poll(dma_pkg::ST_WR_END);
      xreg(dma_pkg::WR_AMT_OFS, 32'(6 - 4 * r));
    end
    xreg(dma_pkg::DROP_OFS, 32'h0);
    repeat (20) @(posedge CLK);
    cmp("notes left", 40'h0, 40'(byte_q.size() + beat_q.size() + reg_q.size()));
    tally_and_finish();
  end
endmodule // peripheral_ram_dma_channel_tb_top
